/* pkg/lcb_pkg.sv */
package lcb_pkg;

    // Register map, byte addresses on the APB bus
    localparam int         LCB_ADDR_W     = 8;
    localparam logic [7:0] LCB_OFS_CMD    = 8'h00;
    localparam logic [7:0] LCB_OFS_TXDATA = 8'h04;
    localparam logic [7:0] LCB_OFS_STATUS = 8'h08;
    localparam logic [7:0] LCB_OFS_RXDATA = 8'h0c;

    // Command word: report identifier above, payload byte below
    localparam int         LCB_ID_LSB     = 8;
    localparam logic [7:0] LCB_ID_ENABLE  = 8'h04;
    localparam logic [7:0] LCB_ID_WRITE   = 8'h05;
    localparam logic [7:0] LCB_ID_READ    = 8'h06;
    localparam logic [7:0] LCB_EN_OFF     = 8'h00;
    localparam logic [7:0] LCB_EN_ON      = 8'h01;

    // Flags byte layout
    localparam int         LCB_FLAG_RS    = 7;
    localparam int         LCB_CNT_W      = 6;
    localparam logic [5:0] LCB_MAX_BYTES  = 6'h3e;
    localparam int         LCB_BUSY_BIT   = 7;

    // Status register bits
    localparam int         LCB_ST_EN      = 0;
    localparam int         LCB_ST_BUSY    = 1;
    localparam int         LCB_ST_REPLY   = 2;

    // Pin levels after reset and in suspend
    localparam logic [10:0] LCB_GPIO_RST  = 11'h7ff;
    localparam logic [7:0]  LCB_DATA_HIGH = 8'hff;

    // Timing at the 40 MHz clock
    localparam int LCB_CLK_KHZ     = 40000;
    localparam int LCB_T_AS_NS     = 60;
    localparam int LCB_T_PW_NS     = 450;
    localparam int LCB_T_GAP_NS    = 500;
    localparam int LCB_AS_CYC      = (LCB_T_AS_NS * LCB_CLK_KHZ + 999999)
                                     / 1000000;
    localparam int LCB_PW_CYC      = (LCB_T_PW_NS * LCB_CLK_KHZ + 999999)
                                     / 1000000;
    localparam int LCB_GAP_CYC     = (LCB_T_GAP_NS * LCB_CLK_KHZ + 999999)
                                     / 1000000;
    localparam int LCB_SEQ_W       = 8;
    localparam int LCB_TIMEOUT_MS  = 16;
    localparam int LCB_TIMEOUT_CYC = LCB_TIMEOUT_MS * LCB_CLK_KHZ;
    localparam int LCB_TMR_W       = 20;

    // Write data buffer
    localparam int LCB_FIFO_W      = 8;
    localparam int LCB_FIFO_DEPTH  = 16;

endpackage : lcb_pkg

/* pkg/lcb_cyc_if.sv */
`timescale 1ns/1ps
interface lcb_cyc_if;
    logic       req;
    logic       rs;
    logic       rw;
    logic [7:0] wdata;
    logic       done;
    logic [7:0] rdata;

    modport master (output req, rs, rw, wdata, input done, rdata);
    modport engine (input req, rs, rw, wdata, output done, rdata);
endinterface : lcb_cyc_if

/* rtl/lcb_fifo.sv */
`timescale 1ns/1ps
module lcb_fifo
    import lcb_pkg::*;
#(
    parameter int WIDTH = LCB_FIFO_W,
    parameter int DEPTH = LCB_FIFO_DEPTH
)(
    input  wire logic             clock_i,     // System clock
    input  wire logic             rst_b_i,     // Async reset, active low
    input  wire logic             clk_en_i,    // Freezes state when low
    input  wire logic             in_valid_i,  // Write side offers data
    output logic                  in_ready_o,  // Room for one word
    input  wire logic [WIDTH-1:0] in_data_i,   // Write data
    output logic                  out_valid_o, // Word available
    input  wire logic             out_ready_i, // Reader takes word
    output logic [WIDTH-1:0]      out_data_o   // Oldest word
);
    localparam int AW = $clog2(DEPTH);

    // Pointers wrap naturally, so DEPTH is a power of two
    logic [WIDTH-1:0] mem_q [0:DEPTH-1];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid_i & in_ready_o;
    wire              pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];

    always_ff @(posedge clock_i)
    begin
        if (clk_en_i && push)
            mem_q[wr_q] <= in_data_i;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else if (clk_en_i)
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule : lcb_fifo

/* rtl/lcb_lcd_cycle.sv */
`timescale 1ns/1ps
module lcb_lcd_cycle
    import lcb_pkg::*;
(
    input  wire logic       clock_i,     // System clock
    input  wire logic       rst_b_i,     // Async reset, active low
    input  wire logic       clk_en_i,    // Freezes state when low
    lcb_cyc_if.engine       cyc,         // One module access
    input  wire logic [7:0] lcd_data_i,  // Data pins from module
    output logic            pin_rs_o,    // Register select level
    output logic            pin_rw_o,    // High for read
    output logic            pin_en_o,    // Enable strobe
    output logic [7:0]      pin_dout_o,  // Write data
    output logic            pin_drive_o  // Data bus driven
);
    typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_GAP} lcb_cy_e;

    lcb_cy_e    st_q;
    logic [7:0] tmr_q;
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] s3_q;
    logic [7:0] stable_q;
    logic [7:0] rdata_q;
    logic       done_q;
    wire        tmr_end = (tmr_q == 8'h00);

    assign cyc.done  = done_q;
    assign cyc.rdata = rdata_q;

    // Pin data settles before it is trusted
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s1_q     <= '0;
            s2_q     <= '0;
            s3_q     <= '0;
            stable_q <= '0;
        end
        else if (clk_en_i)
        begin
            s1_q <= lcd_data_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                stable_q <= s3_q;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_q        <= CY_IDLE;
            tmr_q       <= '0;
            rdata_q     <= '0;
            done_q      <= 1'b0;
            pin_rs_o    <= 1'b0;
            pin_rw_o    <= 1'b1;
            pin_en_o    <= 1'b0;
            pin_dout_o  <= '0;
            pin_drive_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            done_q <= 1'b0;
            case (st_q)
                CY_IDLE:
                begin
                    if (cyc.req)
                    begin
                        pin_rs_o    <= cyc.rs;
                        pin_rw_o    <= cyc.rw;
                        pin_dout_o  <= cyc.wdata;
                        pin_drive_o <= !cyc.rw;
                        tmr_q       <= 8'(LCB_AS_CYC - 1);
                        st_q        <= CY_SETUP;
                    end
                end
                CY_SETUP:
                begin
                    if (tmr_end)
                    begin
                        pin_en_o <= 1'b1;
                        tmr_q    <= 8'(LCB_PW_CYC - 1);
                        st_q     <= CY_PULSE;
                    end
                    else
                        tmr_q <= tmr_q - 8'h01;
                end
                CY_PULSE:
                begin
                    if (tmr_end)
                    begin
                        rdata_q  <= stable_q;
                        pin_en_o <= 1'b0;
                        tmr_q    <= 8'(LCB_GAP_CYC - 1);
                        st_q     <= CY_GAP;
                    end
                    else
                        tmr_q <= tmr_q - 8'h01;
                end
                CY_GAP:
                begin
                    if (tmr_end)
                    begin
                        pin_drive_o <= 1'b0;
                        pin_rw_o    <= 1'b1;
                        done_q      <= 1'b1;
                        st_q        <= CY_IDLE;
                    end
                    else
                        tmr_q <= tmr_q - 8'h01;
                end
                default:
                    st_q <= CY_IDLE;
            endcase
        end
    end
endmodule : lcb_lcd_cycle

/* rtl/lcb_bridge.sv */
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module lcb_bridge
    import lcb_pkg::*;
#(
    parameter int TIMEOUT_CYC = LCB_TIMEOUT_CYC
)(
    input  wire logic        clock_i,       // 40 MHz clock
    input  wire logic        rst_b_i,       // Async reset, active low
    input  wire logic        clk_en_i,      // Freezes state when low
    input  wire logic        suspend_i,     // USB suspend state
    input  wire logic        gpio_we_i,     // Plain pin write strobe
    input  wire logic [10:0] gpio_val_i,    // rs, rw, en, data levels
    input  wire logic        psel_i,        // APB select
    input  wire logic        penable_i,     // APB enable
    input  wire logic        pwrite_i,      // APB write
    input  wire logic [7:0]  paddr_i,       // APB byte address
    input  wire logic [31:0] pwdata_i,      // APB write data
    output logic [31:0]      prdata_o,      // APB read data
    output logic             pready_o,      // APB ready
    output logic             pslverr_o,     // APB error
    input  wire logic [7:0]  lcd_data_i,    // Module data pins in
    output logic             lcd_rs_o,      // Register select pin
    output logic             lcd_rw_o,      // Read/write pin
    output logic             lcd_en_o,      // Enable strobe pin
    output logic [7:0]       lcd_data_o,    // Module data pins out
    output logic [7:0]       lcd_data_oe_o, // Data pin drive enables
    output logic             lcd_on_b_o     // Display power, active low
);
    typedef enum logic [2:0] {
        M_IDLE, M_POLL, M_POLL_W, M_XFER, M_XFER_W, M_DRAIN
    } lcb_mst_e;

    lcb_cyc_if cyc ();

    lcb_mst_e              st_q;
    logic                  enabled_q;
    logic [10:0]           gpio_q;
    logic                  op_rd_q;
    logic                  rs_q;
    logic [LCB_CNT_W-1:0]  remain_q;
    logic [LCB_CNT_W-1:0]  idx_q;
    logic [LCB_TMR_W-1:0]  tmr_q;
    logic                  req_q;
    logic                  req_rs_q;
    logic                  req_rw_q;
    logic [7:0]            req_wd_q;
    logic [7:0]            rx_buf_q [0:LCB_MAX_BYTES-1];
    logic [LCB_CNT_W-1:0]  rx_cnt_q;
    logic [LCB_CNT_W-1:0]  rx_ptr_q;
    logic                  reply_q;
    logic                  pready_q;
    logic                  pslverr_q;
    logic [31:0]           prdata_q;

    wire                   pin_rs;
    wire                   pin_rw;
    wire                   pin_en;
    wire [7:0]             pin_dout;
    wire                   pin_drive;
    wire                   fifo_in_ready;
    wire                   fifo_out_valid;
    wire [7:0]             fifo_out_data;

    // APB decode
    wire        acc     = psel_i & penable_i & !pready_q;
    wire        is_cmd  = (paddr_i == LCB_OFS_CMD);
    wire        is_tx   = (paddr_i == LCB_OFS_TXDATA);
    wire        is_st   = (paddr_i == LCB_OFS_STATUS);
    wire        is_rx   = (paddr_i == LCB_OFS_RXDATA);
    wire        mapped  = is_cmd | is_tx | is_st | is_rx;
    wire        tx_stall = pwrite_i & is_tx & !fifo_in_ready;
    wire        go      = acc & !tx_stall;
    wire        busy    = (st_q != M_IDLE);
    wire        cmd_bad = pwrite_i & is_cmd & busy;
    wire        cmd_wr  = go & pwrite_i & is_cmd & !busy;
    wire        push    = go & pwrite_i & is_tx;
    wire        rx_rd   = go & !pwrite_i & is_rx;
    wire [7:0]  cmd_id  = pwdata_i[LCB_ID_LSB +: 8];
    wire [7:0]  cmd_val = pwdata_i[7:0];
    wire [LCB_CNT_W-1:0] cmd_cnt = cmd_val[LCB_CNT_W-1:0];
    wire [LCB_CNT_W-1:0] clamp_cnt =
        (cmd_cnt > LCB_MAX_BYTES) ? LCB_MAX_BYTES : cmd_cnt;
    wire        cmd_rs  = cmd_val[LCB_FLAG_RS];
    wire        run_ok  = enabled_q & !suspend_i;
    wire        start_wr = cmd_wr & (cmd_id == LCB_ID_WRITE) & run_ok
                           & (clamp_cnt != '0);
    wire        start_rd = cmd_wr & (cmd_id == LCB_ID_READ) & run_ok;
    wire        en_set  = cmd_wr & (cmd_id == LCB_ID_ENABLE)
                          & (cmd_val == LCB_EN_ON);
    wire        en_clr  = cmd_wr & (cmd_id == LCB_ID_ENABLE)
                          & (cmd_val == LCB_EN_OFF);

    // Engine side decode
    wire        timed_out = (tmr_q >= LCB_TMR_W'(TIMEOUT_CYC));
    wire        is_busy   = cyc.rdata[LCB_BUSY_BIT];
    wire        pop       = ((st_q == M_XFER) & !op_rd_q)
                            | (st_q == M_DRAIN & fifo_out_valid & (|remain_q));
    wire        last      = (remain_q == 6'h01);

    // Read data selection
    wire [7:0]  rx_byte = (rx_ptr_q == '0) ? {2'b00, rx_cnt_q}
                          : rx_buf_q[rx_ptr_q - 6'h01];
    wire [31:0] st_word = {29'h0, reply_q, busy, enabled_q};
    wire [31:0] rd_word = is_st ? st_word
                          : is_rx ? {16'h0, LCB_ID_READ, rx_byte}
                          : 32'h0;

    // Pin selection, suspend outranks everything
    wire        own     = enabled_q;
    wire        rs_d    = suspend_i ? 1'b1 : own ? pin_rs : gpio_q[10];
    wire        rw_d    = suspend_i ? 1'b1 : own ? pin_rw : gpio_q[9];
    wire        en_d    = suspend_i ? 1'b1 : own ? pin_en : gpio_q[8];
    wire [7:0]  dout_d  = suspend_i ? LCB_DATA_HIGH
                          : own ? pin_dout : gpio_q[7:0];
    wire [7:0]  doe_d   = suspend_i ? 8'h00
                          : own ? {8{pin_drive}} : ~gpio_q[7:0];
    wire        on_b_d  = !(enabled_q & !suspend_i);

    assign cyc.req   = req_q;
    assign cyc.rs    = req_rs_q;
    assign cyc.rw    = req_rw_q;
    assign cyc.wdata = req_wd_q;

    lcb_fifo #(
        .WIDTH (LCB_FIFO_W),
        .DEPTH (LCB_FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_b_i     (rst_b_i),
        .clk_en_i    (clk_en_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (pwdata_i[7:0]),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_out_data)
    );

    lcb_lcd_cycle u_cycle (
        .clock_i     (clock_i),
        .rst_b_i     (rst_b_i),
        .clk_en_i    (clk_en_i),
        .cyc         (cyc.engine),
        .lcd_data_i  (lcd_data_i),
        .pin_rs_o    (pin_rs),
        .pin_rw_o    (pin_rw),
        .pin_en_o    (pin_en),
        .pin_dout_o  (pin_dout),
        .pin_drive_o (pin_drive)
    );

    // APB answer, one wait state, longer while the buffer is full
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end
        else if (clk_en_i)
        begin
            pready_q  <= go;
            pslverr_q <= go & (!mapped | cmd_bad);
            prdata_q  <= (go & !pwrite_i) ? rd_word : 32'h0;
        end
    end

    // Function enable and plain pin levels
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            enabled_q <= 1'b0;
            gpio_q    <= LCB_GPIO_RST;
        end
        else if (clk_en_i)
        begin
            if (en_set)
                enabled_q <= 1'b1;
            else if (en_clr)
                enabled_q <= 1'b0;
            if (en_set | en_clr)
                gpio_q <= LCB_GPIO_RST;
            else if (gpio_we_i && !enabled_q)
                gpio_q <= gpio_val_i;
        end
    end

    // Pins leave through flops
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            lcd_rs_o      <= 1'b1;
            lcd_rw_o      <= 1'b1;
            lcd_en_o      <= 1'b1;
            lcd_data_o    <= LCB_DATA_HIGH;
            lcd_data_oe_o <= 8'h00;
            lcd_on_b_o    <= 1'b1;
        end
        else if (clk_en_i)
        begin
            lcd_rs_o      <= rs_d;
            lcd_rw_o      <= rw_d;
            lcd_en_o      <= en_d;
            lcd_data_o    <= dout_d;
            lcd_data_oe_o <= doe_d;
            lcd_on_b_o    <= on_b_d;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (clk_en_i && st_q == M_XFER_W && cyc.done && op_rd_q)
            rx_buf_q[idx_q] <= cyc.rdata;
    end

    // Reply pointer; a finishing read wins over the last fetch
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rx_ptr_q <= '0;
            reply_q  <= 1'b0;
            rx_cnt_q <= '0;
        end
        else if (clk_en_i)
        begin
            if (st_q == M_XFER_W && cyc.done && op_rd_q && last)
            begin
                reply_q  <= 1'b1;
                rx_cnt_q <= idx_q + 6'h01;
                rx_ptr_q <= '0;
            end
            else if (rx_rd && reply_q)
            begin
                if (rx_ptr_q == rx_cnt_q)
                begin
                    reply_q  <= 1'b0;
                    rx_ptr_q <= '0;
                end
                else
                    rx_ptr_q <= rx_ptr_q + 6'h01;
            end
        end
    end

    // Transaction engine
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_q     <= M_IDLE;
            op_rd_q  <= 1'b0;
            rs_q     <= 1'b0;
            remain_q <= '0;
            idx_q    <= '0;
            tmr_q    <= '0;
            req_q    <= 1'b0;
            req_rs_q <= 1'b0;
            req_rw_q <= 1'b1;
            req_wd_q <= '0;
        end
        else if (clk_en_i)
        begin
            req_q <= 1'b0;
            if (st_q == M_POLL_W || (st_q == M_POLL && |tmr_q))
                tmr_q <= tmr_q + 1'b1;
            case (st_q)
                M_IDLE:
                begin
                    tmr_q <= '0;
                    idx_q <= '0;
                    if (start_wr)
                    begin
                        op_rd_q  <= 1'b0;
                        rs_q     <= cmd_rs;
                        remain_q <= clamp_cnt;
                        st_q     <= M_POLL;
                    end
                    else if (start_rd && !cmd_rs)
                    begin
                        op_rd_q  <= 1'b1;
                        rs_q     <= 1'b0;
                        remain_q <= 6'h01;
                        st_q     <= M_XFER;
                    end
                    else if (start_rd && clamp_cnt != '0)
                    begin
                        op_rd_q  <= 1'b1;
                        rs_q     <= 1'b1;
                        remain_q <= clamp_cnt;
                        st_q     <= M_POLL;
                    end
                end
                M_POLL:
                begin
                    if (op_rd_q || fifo_out_valid)
                    begin
                        req_q    <= 1'b1;
                        req_rs_q <= 1'b0;
                        req_rw_q <= 1'b1;
                        st_q     <= M_POLL_W;
                    end
                end
                M_POLL_W:
                begin
                    if (cyc.done && !is_busy)
                        st_q <= M_XFER;
                    else if (cyc.done && timed_out)
                        st_q <= op_rd_q ? M_IDLE : M_DRAIN;
                    else if (cyc.done)
                        st_q <= M_POLL;
                end
                M_XFER:
                begin
                    req_q    <= 1'b1;
                    req_rs_q <= rs_q;
                    req_rw_q <= op_rd_q;
                    req_wd_q <= fifo_out_data;
                    st_q     <= M_XFER_W;
                end
                M_XFER_W:
                begin
                    if (cyc.done)
                    begin
                        remain_q <= remain_q - 6'h01;
                        tmr_q    <= '0;
                        if (last)
                            st_q <= M_IDLE;
                        else
                        begin
                            idx_q <= idx_q + 6'h01;
                            st_q  <= M_POLL;
                        end
                    end
                end
                M_DRAIN:
                begin
                    // Bytes of an abandoned write are discarded
                    if (remain_q == '0)
                        st_q <= M_IDLE;
                    else if (fifo_out_valid)
                        remain_q <= remain_q - 6'h01;
                end
                default:
                    st_q <= M_IDLE;
            endcase
        end
    end

    assign prdata_o  = prdata_q;
    assign pready_o  = pready_q;
    assign pslverr_o = pslverr_q;
endmodule : lcb_bridge

/* bench/lcb_bridge_checker.sv */
`timescale 1ns/1ps
module lcb_bridge_checker (
    input wire logic       clock_i,       // Clock
    input wire logic       rst_b_i,       // Reset
    input wire logic       suspend_i,     // Suspend
    input wire logic       pready_o,      // Ready
    input wire logic       lcd_rs_o,      // Select
    input wire logic       lcd_rw_o,      // Read
    input wire logic       lcd_en_o,      // Strobe
    input wire logic [7:0] lcd_data_oe_o, // Drive
    input wire logic       lcd_on_b_o     // Power
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);
    wire act = !lcd_on_b_o;

    chk_susp_high: assert property (suspend_i[*4] |-> lcd_on_b_o
        && lcd_en_o && lcd_rs_o && lcd_rw_o && lcd_data_oe_o == 8'h00)
        else $error("pins low in suspend");
    chk_power_rel: assert property ($rose(suspend_i)
        |-> ##[1:3] lcd_on_b_o) else $error("power kept");
    chk_en_setup: assert property (act && $rose(lcd_en_o)
        |-> $stable(lcd_rs_o) && $stable(lcd_rw_o))
        else $error("select moved with strobe");
    chk_en_width: assert property (act && $rose(lcd_en_o)
        |-> lcd_en_o[*8]) else $error("strobe short");
    chk_en_gap: assert property (act && $past(act) && $fell(lcd_en_o)
        |-> (!lcd_en_o)[*8]) else $error("gap short");
    chk_wr_drive: assert property (act && lcd_en_o && !lcd_rw_o
        |-> lcd_data_oe_o == 8'hff) else $error("write not driven");
    chk_rd_float: assert property (act && lcd_en_o && lcd_rw_o
        |-> lcd_data_oe_o == 8'h00) else $error("read driven");
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready stuck");
endmodule : lcb_bridge_checker
bind lcb_bridge lcb_bridge_checker u_chk (.clock_i, .rst_b_i, .suspend_i,
    .pready_o, .lcd_rs_o, .lcd_rw_o, .lcd_en_o, .lcd_data_oe_o, .lcd_on_b_o);

/* bench/lcb_lcd_model.sv */
`timescale 1ns/1ps
module lcb_lcd_model (
    input  wire logic       clock_i, // Clock
    input  wire logic       rs_i,    // Select
    input  wire logic       rw_i,    // Read
    input  wire logic       en_i,    // Strobe
    input  wire logic [7:0] bus_i,   // Bus level
    input  wire logic [7:0] busy_i,  // Busy span
    input  wire logic       hang_i,  // Stuck busy
    output logic [7:0]      dout_o,  // Read data
    output logic            wr_o,    // Write taken
    output logic [8:0]      wr_o_v   // Select, byte
);
    logic [7:0] busy_q = 8'h00;
    logic [7:0] rd_q = 8'h30;
    logic       en_q = 1'b0;
    wire        busy = hang_i || busy_q != 8'h00;
    wire        take = en_q && !en_i && !rw_i && !busy;
    assign dout_o = rs_i ? rd_q : {busy, 7'h15};
    always_ff @(posedge clock_i)
    begin
        en_q <= en_i;
        wr_o <= take;
        wr_o_v <= {rs_i, bus_i};
        if (take)
            busy_q <= busy_i;
        else if (busy_q != 8'h00)
            busy_q <= busy_q - 8'h01;
        // Writes set the address, data reads step it
        if (take)
            rd_q <= 8'h30;
        else if (en_q && !en_i && rs_i)
            rd_q <= rd_q + 8'h01;
    end
endmodule : lcb_lcd_model

/* bench/lcb_bridge_tb.sv */
`timescale 1ns/1ps
module lcb_bridge_tb;
    import lcb_pkg::*;
    logic clock_i = 0, rst_b_i = 0, sus = 0, gwe = 0, hang = 0, psel = 0;
    logic pen = 0, pwr = 0, rdy, err, er, en, rs, rw, onb, wr;
    logic [7:0] pa = 0, busy = 8'h10, dq, oe, md, lvl, mv;
    logic [10:0] gv = 0;
    logic [31:0] pwd = 0, prd, rd;
    logic [8:0] wv, exp_q[$];
    int error_cnt = 0, comparisons = 0;
    always #12.5 clock_i = ~clock_i;
    // Pull-ups hold undriven data lines high
    assign lvl = (oe & dq) | (~oe & ((en & rw) ? md : 8'hff));
    lcb_bridge #(.TIMEOUT_CYC(400)) u_lcb_bridge (.clock_i, .rst_b_i,
        .clk_en_i(1'b1), .suspend_i(sus), .gpio_we_i(gwe), .gpio_val_i(gv),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
        .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
        .lcd_data_i(lvl), .lcd_rs_o(rs), .lcd_rw_o(rw), .lcd_en_o(en),
        .lcd_data_o(dq), .lcd_data_oe_o(oe), .lcd_on_b_o(onb));
    lcb_lcd_model u_lcb_lcd_model (.clock_i, .rs_i(rs), .rw_i(rw), .en_i(en),
        .bus_i(lvl), .busy_i(busy), .hang_i(hang), .dout_o(md), .wr_o(wr),
        .wr_o_v(wv));
    task automatic chk(input string s, input logic [31:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge clock_i);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clock_i);
        pen <= 1'b1;
        do
            @(posedge clock_i);
        while (rdy !== 1'b1);
        rd = prd;
        er = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic idle();
        do
            apb(1'b0, LCB_OFS_STATUS, 0);
        while (rd[LCB_ST_BUSY] !== 1'b0);
        $display("operation done");
    endtask : idle
    task automatic wr_op(input logic r, input int c, input logic keep);
        logic [7:0] b;
        apb(1'b1, LCB_OFS_CMD, {LCB_ID_WRITE, r, 1'b0, 6'(c)});
        repeat (c)
        begin
            b = 8'($urandom);
            if (keep)
                exp_q.push_back({r, b});
            apb(1'b1, LCB_OFS_TXDATA, b);
        end
        idle();
    endtask : wr_op
    task automatic rd_op(input logic r, input int c);
        apb(1'b1, LCB_OFS_CMD, {LCB_ID_READ, r, 1'b0, 6'(c)});
        idle();
        apb(1'b0, LCB_OFS_RXDATA, 0);
        chk("count", {LCB_ID_READ, r ? 8'(c) : 8'h01}, rd);
        for (mv = 8'h30; mv < (r ? 8'h30 + c : 8'h31); mv++)
        begin
            apb(1'b0, LCB_OFS_RXDATA, 0);
            chk("data", {LCB_ID_READ, r ? mv : 8'h15}, rd);
        end
    endtask : rd_op
    task automatic gp();
        @(posedge clock_i);
        gwe <= 1'b1;
        gv <= 11'h700;
        @(posedge clock_i);
        gwe <= 1'b0;
        repeat (3) @(posedge clock_i);
    endtask : gp
    task automatic end_sim();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    always @(posedge clock_i)
        if (wr === 1'b1)
            chk("lcd", exp_q.size() ? exp_q.pop_front() : 'x, wv);
    initial
    begin
        #2_500_000;
        error_cnt++;
        end_sim();
    end
    initial
    begin
        void'($urandom(32'h6ec41d41));
        repeat (3) @(posedge clock_i);
        rst_b_i <= 1'b1;
        gp();
        chk("plain", 8'hff, oe);
        apb(1'b1, LCB_OFS_CMD, {LCB_ID_ENABLE, LCB_EN_ON});
        gp();
        chk("owned", {9'h0, 8'h00}, {onb, oe});
        apb(1'b0, 8'h10, 0);
        chk("unmapped", 1'b1, er);
        for (int i = 0; i < 2; i++)
        begin
            busy <= 8'($urandom_range(200, 8));
            wr_op(i, i ? 62 : $urandom_range(16, 1), 1'b1);
            chk("left", 0, exp_q.size());
        end
        rd_op(1'b1, $urandom_range(8, 1));
        repeat (300) @(posedge clock_i);
        rd_op(1'b0, 5);
        hang <= 1'b1;
        wr_op(1'b1, 3, 1'b0);
        chk("silent", 1'b0, rd[LCB_ST_REPLY]);
        hang <= 1'b0;
        sus <= 1'b1;
        repeat (5) @(posedge clock_i);
        chk("suspend", 12'hf00, {onb, en, rs, rw, oe});
        sus <= 1'b0;
        apb(1'b1, LCB_OFS_CMD, {LCB_ID_ENABLE, 8'h02});
        chk("reserved", 1'b0, onb);
        apb(1'b1, LCB_OFS_CMD, {LCB_ID_ENABLE, LCB_EN_OFF});
        repeat (3) @(posedge clock_i);
        chk("off", 1'b1, onb);
        end_sim();
    end
endmodule : lcb_bridge_tb
